// file: src/microword_misc_pkg.sv
// Package of field codes and widths for the microword miscellaneous control block
package microword_misc_pkg;

	// ****************************************
	// Field widths
	// ****************************************
	localparam int FIELD_W = 4;
	localparam int NEXT_LO_W = 2;
	localparam int INTR_W = 8;
	localparam int RESULT_W = 9;
	localparam int SUM_W = 8;

	// ****************************************
	// Alternate constant-field action codes
	// ****************************************
	localparam logic [3:0] ALT_CARRY_FORCED = 4'h5;
	localparam logic [3:0] ALT_FAULT_INJECT = 4'h6;
	localparam logic [3:0] ALT_CHARSET_TEST = 4'h7;
	localparam logic [3:0] ALT_CLR_INIT_LOAD = 4'hB;
	localparam logic [3:0] ALT_INTR_RESET = 4'hC;
	localparam logic [3:0] ALT_INTR_BIT0_SET = 4'hD;

	// ****************************************
	// Other field codes
	// ****************************************
	localparam logic [3:0] DEST_PRIORITY = 4'h5;
	localparam logic [3:0] ASRC_J_REG = 4'hE;
	localparam logic [2:0] AGATE_STOP = 3'h7;

	// ****************************************
	// Reset values and bit positions
	// ****************************************
	localparam logic [7:0] INTR_RESET_VAL = 8'hFF;
	localparam logic [1:0] NEXT_LO_CLEAR = 2'h0;
	localparam int INTR_BIT0 = 0;
	localparam int RESULT_BIT_A = 0;
	localparam int RESULT_BIT_B = 4;

endpackage

// file: src/pulse_latch.sv
// Set/reset latch clocked by mclk, with set-over-clear priority option
`timescale 1ns/1ps
`default_nettype none
module pulse_latch #(
	parameter bit SET_WINS = 1'b1
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Controls
	input wire logic set_i,
	input wire logic clr_i,
	// State
	output logic q
);
	// ****************************************
	// Latch storage
	// ****************************************
	typedef struct packed {
		logic q_r;
	} latch_state_t;

	latch_state_t st_r;
	latch_state_t st_nxt;

	// Next state; the priority choice picks which of a coincident set and clear wins
	always_comb begin
		st_nxt = st_r;
		if (SET_WINS) begin
			if (clr_i)
				st_nxt.q_r = 1'b0;
			if (set_i)
				st_nxt.q_r = 1'b1;
		end else begin
			if (set_i)
				st_nxt.q_r = 1'b1;
			if (clr_i)
				st_nxt.q_r = 1'b0;
		end
	end

	// Register
	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign q = st_r.q_r;
endmodule
`default_nettype wire

// file: src/microword_misc_control.sv
// Miscellaneous microword control: forced branch, fault inject, stops, interrupt reg
`timescale 1ns/1ps
`default_nettype none
module microword_misc_control (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// CPU cycle pulses
	input wire logic t1,
	input wire logic t2,
	input wire logic t3,
	input wire logic t4,
	// Microword fields
	input wire logic [3:0] constant_field,
	input wire logic alt_const_active,
	input wire logic [3:0] alu_dest_field,
	input wire logic [3:0] a_source_field,
	input wire logic [2:0] a_gating_field,
	input wire logic [1:0] next_addr_field,
	// Branch conditions tested by the high and low condition fields
	input wire logic high_cond_value,
	input wire logic low_cond_value,
	// Datapath and machine status
	input wire logic prev_carry_out,
	input wire logic charset_latch,
	input wire logic process_stop_sw,
	input wire logic compat_mode,
	input wire logic share_req_pending,
	input wire logic intr_bit_set_ext,
	input wire logic [2:0] intr_bit_sel_ext,
	input wire logic [8:0] result_bus_in,
	input wire logic [7:0] sum_n_in,
	input wire logic carry0_n_in,
	// Register-style control port
	input wire logic [3:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Next-address outputs
	output logic upper_branch_bit,
	output logic lower_branch_bit,
	output logic next_addr_load_en,
	// Injection outputs
	output logic [8:0] result_bus_out,
	output logic [7:0] sum_n_out,
	output logic carry0_n_out,
	// Stop and control outputs
	output logic microprogram_stop,
	output logic process_loop_stop,
	output logic clock_start,
	output logic compat_addr_gate,
	output logic priority_latch,
	output logic odd_even_even,
	output logic alu_check_latch,
	output logic [7:0] intr_reg
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [7:0] intr_r;
		logic prio_ctl_r;
		logic prio_r;
		logic stop_r;
		logic clk_start_r;
		logic upper_r;
		logic lower_r;
		logic [7:0] rdata_r;
		logic [7:0] prio_req_r;
	} ctl_state_t;

	ctl_state_t st_r;
	ctl_state_t st_nxt;

	// Decoded actions
	logic act_carry_forced;
	logic act_fault_inject;
	logic act_charset;
	logic act_clr_load;
	logic act_intr_reset;
	logic act_intr_bit0;
	logic act_stop;
	logic j_selected;
	logic stop_plain;
	logic stop_loop;
	logic oe_set;
	logic oe_clr;
	logic chk_set;
	logic chk_clr;
	logic oe_q;
	logic chk_q;

	// ****************************************
	// Decode
	// ****************************************
	// Alternate constant actions only exist when the alternate field is active
	assign act_carry_forced = alt_const_active &&
		(constant_field == microword_misc_pkg::ALT_CARRY_FORCED);
	assign act_fault_inject = alt_const_active &&
		(constant_field == microword_misc_pkg::ALT_FAULT_INJECT);
	assign act_charset = alt_const_active &&
		(constant_field == microword_misc_pkg::ALT_CHARSET_TEST);
	assign act_clr_load = alt_const_active &&
		(constant_field == microword_misc_pkg::ALT_CLR_INIT_LOAD);
	assign act_intr_reset = alt_const_active &&
		(constant_field == microword_misc_pkg::ALT_INTR_RESET);
	assign act_intr_bit0 = alt_const_active &&
		(constant_field == microword_misc_pkg::ALT_INTR_BIT0_SET);
	// Stop code means compat gating instead in compatibility mode
	assign act_stop = (a_gating_field == microword_misc_pkg::AGATE_STOP) && !compat_mode;
	assign compat_addr_gate = (a_gating_field == microword_misc_pkg::AGATE_STOP) &&
		compat_mode;
	assign j_selected = (a_source_field == microword_misc_pkg::ASRC_J_REG);

	// ****************************************
	// Fault-inject latches
	// ****************************************
	// Odd-even latch: EVEN set on first use at T2; cleared by load action or T2 with check
	assign oe_set = act_fault_inject && t2 && !chk_q;
	assign oe_clr = act_clr_load || (t2 && chk_q);
	// Repeat use (latch already EVEN) sets the check latch at T1
	assign chk_set = act_fault_inject && t1 && oe_q;
	assign chk_clr = (act_fault_inject && t2 && !oe_q) || act_clr_load;

	pulse_latch #(
		.SET_WINS(1'b0)
	) u_odd_even (
		.mclk(mclk),
		.reset(reset),
		.set_i(oe_set),
		.clr_i(oe_clr),
		.q(oe_q)
	);

	pulse_latch #(
		.SET_WINS(1'b1)
	) u_alu_check (
		.mclk(mclk),
		.reset(reset),
		.set_i(chk_set),
		.clr_i(chk_clr),
		.q(chk_q)
	);

	// Injection gates; bad parity only in ODD state: at T1-T2 of first use, and at T3-T4 of a repeat use once T2 has cleared the latch
	always_comb begin
		result_bus_out = result_bus_in;
		if (act_fault_inject && !oe_q) begin
			result_bus_out[microword_misc_pkg::RESULT_BIT_A] = 1'b0;
			result_bus_out[microword_misc_pkg::RESULT_BIT_B] = 1'b0;
		end
		sum_n_out = chk_q ? '1 : sum_n_in;
		carry0_n_out = chk_q ? 1'b1 : carry0_n_in;
	end

	// ****************************************
	// Stop outputs
	// ****************************************
	assign stop_plain = st_r.stop_r && !j_selected;
	assign stop_loop = st_r.stop_r && j_selected && process_stop_sw;
	assign microprogram_stop = stop_plain;
	assign process_loop_stop = stop_loop;
	// Next address held so the loop returns to the stop word
	assign next_addr_load_en = !stop_loop;

	// ****************************************
	// Next state
	// ****************************************
	// Branch bits recomputed every cycle from the current inputs while next_addr_load_en is high
	always_comb begin
		st_nxt = st_r;
		st_nxt.rdata_r = 8'h00;
		// Branch bits follow tested conditions
		if (next_addr_load_en) begin
			st_nxt.upper_r = high_cond_value;
			st_nxt.lower_r = low_cond_value;
			if (act_charset && charset_latch)
				st_nxt.upper_r = 1'b0;
			if (act_carry_forced && prev_carry_out) begin
				{st_nxt.upper_r, st_nxt.lower_r} = microword_misc_pkg::NEXT_LO_CLEAR;
			end
		end
		// Priority handling
		if (alu_dest_field == microword_misc_pkg::DEST_PRIORITY)
			st_nxt.prio_ctl_r = 1'b1;
		if (st_r.prio_ctl_r && t3) begin
			st_nxt.prio_r = 1'b0;
			st_nxt.prio_ctl_r = 1'b0;
		end
		if (|st_r.prio_req_r)
			st_nxt.prio_r = 1'b1;
		// Stop latch
		if (act_stop && t4)
			st_nxt.stop_r = 1'b1;
		if (!act_stop && t4)
			st_nxt.stop_r = 1'b0;
		// Clock runs for share requests only in a loop stop, then stops; a plain stop stops it at once
		if (stop_plain)
			st_nxt.clk_start_r = 1'b0;
		else if (stop_loop && !share_req_pending)
			st_nxt.clk_start_r = 1'b0;
		else if (!st_r.stop_r)
			st_nxt.clk_start_r = 1'b1;
		// Interrupt register, active low bits; external sets apply in any cycle, microword actions late at T4
		if (intr_bit_set_ext)
			st_nxt.intr_r[intr_bit_sel_ext] = 1'b0;
		if (act_intr_reset && t4)
			st_nxt.intr_r = microword_misc_pkg::INTR_RESET_VAL;
		if (act_intr_bit0 && t4)
			st_nxt.intr_r[microword_misc_pkg::INTR_BIT0] = 1'b0;
		// Register port: write addr 0 priority requests; read addr 0 interrupt register, addr 1 status
		st_nxt.prio_req_r = 8'h00;
		if (reg_wr && reg_addr == 4'h0)
			st_nxt.prio_req_r = reg_wdata;
		if (reg_rd) begin
			case (reg_addr)
				4'h0: st_nxt.rdata_r = st_r.intr_r;
				4'h1: st_nxt.rdata_r = {2'h0, oe_q, chk_q, st_r.prio_r,
					st_r.stop_r, stop_loop, st_r.clk_start_r};
				default: st_nxt.rdata_r = 8'h00;
			endcase
		end
	end

	// State register
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			st_r <= '0;
			st_r.intr_r <= microword_misc_pkg::INTR_RESET_VAL;
			st_r.clk_start_r <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign upper_branch_bit = st_r.upper_r;
	assign lower_branch_bit = st_r.lower_r;
	assign clock_start = st_r.clk_start_r;
	assign priority_latch = st_r.prio_r;
	assign odd_even_even = oe_q;
	assign alu_check_latch = chk_q;
	assign intr_reg = st_r.intr_r;
	assign reg_rdata = st_r.rdata_r;
endmodule
`default_nettype wire

// file: sim/microword_misc_assertions.sv
// Checker of port relations for the miscellaneous microword control block
`timescale 1ns/1ps
`default_nettype none
module microword_misc_assertions (
	// Clock, reset and cycle pulses
	input wire logic mclk,
	input wire logic reset,
	input wire logic t1,
	input wire logic t2,
	input wire logic t4,
	// Microword fields and levels
	input wire logic alt_const_active,
	input wire logic [3:0] constant_field,
	input wire logic [3:0] a_source_field,
	input wire logic [2:0] a_gating_field,
	input wire logic prev_carry_out,
	input wire logic compat_mode,
	// Outputs under watch
	input wire logic upper_branch_bit,
	input wire logic lower_branch_bit,
	input wire logic next_addr_load_en,
	input wire logic [8:0] result_bus_out,
	input wire logic [7:0] sum_n_out,
	input wire logic carry0_n_out,
	input wire logic microprogram_stop,
	input wire logic process_loop_stop,
	input wire logic odd_even_even,
	input wire logic alu_check_latch,
	input wire logic [7:0] intr_reg
);
	// ********
	// Decode
	// ********
	logic fi, cfb, irs, jsel;
	// Alternate actions count only with their valid bit
	assign fi = alt_const_active && constant_field == microword_misc_pkg::ALT_FAULT_INJECT;
	assign cfb = alt_const_active && constant_field == microword_misc_pkg::ALT_CARRY_FORCED;
	assign irs = alt_const_active && constant_field == microword_misc_pkg::ALT_INTR_RESET;
	assign jsel = a_source_field == microword_misc_pkg::ASRC_J_REG;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	// ********
	// Assertions
	// ********
	carry_branch_a:
	assert property (cfb && prev_carry_out && next_addr_load_en
		|=> !upper_branch_bit && !lower_branch_bit) else $error("forced branch not leg 00");
	parity_block_a:
	assert property (fi && !odd_even_even |-> result_bus_out[0] == 1'b0
		&& result_bus_out[4] == 1'b0) else $error("result lines 0 and 4 not blocked");
	check_force_a:
	assert property (alu_check_latch |-> sum_n_out == 8'hFF && carry0_n_out)
		else $error("sum and carry lines not forced high");
	even_set_a:
	assert property (fi && t2 && !alu_check_latch |=> odd_even_even && !alu_check_latch)
		else $error("fault inject at T2 did not select even");
	check_set_a:
	assert property (fi && t1 && odd_even_even |=> alu_check_latch)
		else $error("check latch not set at T1");
	odd_clear_a:
	assert property (t2 && alu_check_latch |=> !odd_even_even)
		else $error("odd-even latch not cleared at T2");
	stop_set_a:
	assert property (t4 && a_gating_field == microword_misc_pkg::AGATE_STOP && !compat_mode
		|=> microprogram_stop || jsel) else $error("stop word did not stop");
	mp_stop_a:
	assert property (microprogram_stop |-> !jsel && next_addr_load_en)
		else $error("microprogram stop with J source");
	loop_stop_a:
	assert property (process_loop_stop |-> !next_addr_load_en && !microprogram_stop)
		else $error("loop stop did not block address load");
	intr_reset_a:
	assert property (irs && t4 |=> intr_reg == 8'hFF)
		else $error("interrupt register not all ones");
endmodule
bind microword_misc_control microword_misc_assertions u_chk (.*);
`default_nettype wire

// file: sim/cpu_cycle_model.sv
// Model of the sequencer side that hands out the four cycle pulses
`timescale 1ns/1ps
`default_nettype none
module cpu_cycle_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// One-hot cycle pulses
	output logic t1,
	output logic t2,
	output logic t3,
	output logic t4
);
	logic [3:0] phase_r;
	// Rotate one hot; reset parks on T4 so each word opens with T1
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			phase_r <= 4'h8;
		end else begin
			phase_r <= {phase_r[2:0], phase_r[3]};
		end
	end
	assign {t4, t3, t2, t1} = phase_r;
endmodule
`default_nettype wire

// file: sim/test_microword_misc_control.sv
// Self-checking bench for the miscellaneous microword control block
`timescale 1ns/1ps
`default_nettype none
module test_microword_misc_control;
	localparam logic [3:0] FB = microword_misc_pkg::ALT_CARRY_FORCED;
	localparam logic [3:0] FI = microword_misc_pkg::ALT_FAULT_INJECT;
	localparam logic [3:0] CS = microword_misc_pkg::ALT_CHARSET_TEST;
	localparam logic [3:0] IB = microword_misc_pkg::ALT_INTR_BIT0_SET;
	localparam logic [3:0] IR = microword_misc_pkg::ALT_INTR_RESET;
	logic mclk, reset, t1, t2, t3, t4, alt_const_active, high_cond_value, low_cond_value;
	logic prev_carry_out, charset_latch, process_stop_sw, compat_mode, share_req_pending;
	logic intr_bit_set_ext, reg_wr, reg_rd, upper_branch_bit, lower_branch_bit, clock_start;
	logic next_addr_load_en, carry0_n_out, microprogram_stop, process_loop_stop;
	logic compat_addr_gate, priority_latch, odd_even_even, alu_check_latch;
	logic [2:0] a_gating_field, intr_bit_sel_ext;
	logic [3:0] constant_field, alu_dest_field, a_source_field, reg_addr;
	logic [7:0] reg_wdata, reg_rdata, sum_n_out, intr_reg;
	logic [8:0] result_bus_out;
	int n_fail, comparisons;
	cpu_cycle_model u_cyc (.*);
	microword_misc_control u_dut (.*, .next_addr_field(2'h0), .result_bus_in(9'h1FF),
		.sum_n_in(8'h00), .carry0_n_in(1'b0));
	// Free-running clock
	always #2 mclk = ~mclk;
	task automatic check(input logic [8:0] seen, input logic [8:0] want);
		comparisons++;
		if (seen !== want) begin
			n_fail++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// One word from T1 to T4; returns on its opening edge, before updates land
	task automatic word(input logic [3:0] cf, input logic [3:0] dest = 4'h0,
		input logic [3:0] asrc = 4'h0, input logic [2:0] gate = 3'h0);
		int i;
		i = 0;
		do begin
			@(posedge mclk);
			i++;
		end while (t4 !== 1'b1 && i < 8);
		if (t4 !== 1'b1) begin
			check(t4, 1'b1);
			print_verdict();
		end
		alt_const_active <= cf != 4'h0;
		constant_field <= cf;
		alu_dest_field <= dest;
		a_source_field <= asrc;
		a_gating_field <= gate;
	endtask
	task automatic reg_op(input logic wr, input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= wr;
		reg_rd <= !wr;
		@(posedge mclk);
		{reg_wr, reg_rd} <= 2'b00;
		@(posedge mclk);
		if (!wr) check(reg_rdata, d);
	endtask
	task automatic test_regs();
		reg_op(0, 4'h1, 8'h01);
		reg_op(0, 4'hF, 8'h00);
		reg_op(1, 4'h0, 8'h01);
		reg_op(0, 4'h1, 8'h09);
		word(4'h0, microword_misc_pkg::DEST_PRIORITY);
		word(4'h0);
		check(priority_latch, 1'b0);
		$display("register and priority test done");
	endtask
	task automatic test_fault();
		word(FI);
		@(posedge mclk);
		check(result_bus_out, 9'h1EE);
		word(4'h0);
		check({odd_even_even, alu_check_latch}, 2'b10);
		word(FI);
		@(posedge mclk);
		check(result_bus_out, 9'h1FF);
		@(posedge mclk);
		check({alu_check_latch, sum_n_out, carry0_n_out}, 9'h1FF);
		word(microword_misc_pkg::ALT_CLR_INIT_LOAD);
		check(odd_even_even, 1'b0);
		word(4'h0);
		check({odd_even_even, alu_check_latch}, 2'b00);
		$display("fault inject test done");
	endtask
	task automatic test_branch();
		{high_cond_value, low_cond_value, prev_carry_out} <= 3'b111;
		word(FB);
		word(4'h0);
		check({upper_branch_bit, lower_branch_bit}, 2'b00);
		{low_cond_value, prev_carry_out} <= 2'b00;
		word(FB);
		word(4'h0);
		check({upper_branch_bit, lower_branch_bit}, 2'b10);
		{charset_latch, low_cond_value} <= 2'b11;
		word(CS);
		word(4'h0);
		check({upper_branch_bit, lower_branch_bit}, 2'b01);
		charset_latch <= 1'b0;
		$display("branch test done");
	endtask
	task automatic test_stop();
		word(4'h0, 4'h0, 4'h0, microword_misc_pkg::AGATE_STOP);
		word(4'h0);
		@(posedge mclk);
		check({microprogram_stop, process_loop_stop}, 2'b10);
		@(posedge mclk);
		check(clock_start, 1'b0);
		{process_stop_sw, share_req_pending} <= 2'b11;
		word(4'h0, 4'h0, microword_misc_pkg::ASRC_J_REG, microword_misc_pkg::AGATE_STOP);
		word(4'h0, 4'h0, microword_misc_pkg::ASRC_J_REG);
		@(posedge mclk);
		check({process_loop_stop, next_addr_load_en, microprogram_stop}, 3'b100);
		// Clock keeps running while a share request waits, stops once it is served
		share_req_pending <= 1'b0;
		@(posedge mclk);
		check(clock_start, 1'b1);
		@(posedge mclk);
		check(clock_start, 1'b0);
		compat_mode <= 1'b1;
		word(4'h0, 4'h0, 4'h0, microword_misc_pkg::AGATE_STOP);
		@(posedge mclk);
		check(compat_addr_gate, 1'b1);
		{compat_mode, process_stop_sw, share_req_pending} <= 3'b000;
		$display("stop test done");
	endtask
	task automatic test_intr();
		{intr_bit_set_ext, intr_bit_sel_ext} <= 4'hB;
		@(posedge mclk);
		intr_bit_set_ext <= 1'b0;
		word(IB);
		word(4'h0);
		@(posedge mclk);
		check(intr_reg, 8'hF6);
		word(IR);
		word(4'h0);
		@(posedge mclk);
		check(intr_reg, 8'hFF);
		$display("interrupt register test done");
	endtask
	// Quiet inputs at time zero, reset, then the scenarios
	initial begin
		{mclk, reset, n_fail, comparisons} = {2'b01, 64'h0};
		{alt_const_active, constant_field, alu_dest_field, a_source_field, a_gating_field} = '0;
		{high_cond_value, low_cond_value, prev_carry_out, charset_latch, process_stop_sw} = '0;
		{compat_mode, share_req_pending, intr_bit_set_ext, intr_bit_sel_ext} = '0;
		{reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
		repeat (20) @(posedge mclk);
		reset <= 1'b0;
		test_regs();
		test_fault();
		test_branch();
		test_stop();
		test_intr();
		print_verdict();
	end
endmodule
`default_nettype wire
